// [hw/aic_defines.vh]
// Constants for the analogue input conditioning block.
// Included by every design file of the block; definitions only.
`ifndef AIC_DEFINES_VH
`define AIC_DEFINES_VH

// Input function codes
`define AIC_FN_OFF 2'h0
`define AIC_FN_PROCESS 2'h3

// Range setup codes
`define AIC_SU_4_20MA 3'h0
`define AIC_SU_0_20MA 3'h1
`define AIC_SU_USER_CURRENT_RANGE 3'h2
`define AIC_SU_0_10V 3'h4
`define AIC_SU_2_10V 3'h5
`define AIC_SU_USER_V 3'h6

// Process end select codes
`define AIC_PS_MIN 2'h0
`define AIC_PS_MAX 2'h1
`define AIC_PS_USER 2'h2

// Gate select codes
`define AIC_GT_ON 2'h0
`define AIC_GT_LOW 2'h1
`define AIC_GT_HIGH 2'h2

// Digital input function code for gate control
`define AIC_DI_GATE_FN 5'h0b

// Physical levels in units of 10 uA or 10 mV (hundredths of mA / V)
`define AIC_PHY_ZERO 16'h0000
`define AIC_PHY_4MA 16'h0190
`define AIC_PHY_20MA 16'h07d0
`define AIC_PHY_2V 16'h00c8
`define AIC_PHY_10V 16'h03e8

// Process value limits, thousandths: +/- 10000.000
`define AIC_PV_LIMIT 32'h00989680
`define AIC_PV_ZERO 32'h00000000

// Filter time constant in ms, limits and default
`define AIC_TC_MIN_MS 16'h0001
`define AIC_TC_MAX_MS 16'h2710
`define AIC_TC_DEF_MS 16'h0064

// Cycles of mclk per millisecond at 125 MHz
`define AIC_CLK_KHZ 125000
`define AIC_MS_CYCLES 17'h1e848

`endif

// [hw/aic_lowpass.v]
// First-order smoothing filter with a millisecond step.
// Expects a one-cycle step enable and a time constant in steps.
`timescale 1ns/1ps
`include "aic_defines.vh"

module aic_lowpass #(
    parameter W = 32,
    parameter TCW = 16
) (
    input wire mclk,
    input wire rst_b,
    input wire step_en,
    input wire load,
    input wire [TCW-1:0] tc_steps,
    input wire signed [W-1:0] x_in,
    output reg signed [W-1:0] y_ff
);
    reg signed [W+TCW:0] acc_ff;
    reg signed [W+TCW:0] nxt_acc;
    reg signed [W+TCW:0] quot;
    reg signed [W-1:0] nxt_y;
    reg [TCW-1:0] tc_seen_ff;
    wire signed [W+TCW:0] x_ext;
    wire signed [W+TCW:0] y_ext;
    wire signed [W+TCW:0] tc_ext;

    assign x_ext = {{(TCW+1){x_in[W-1]}}, x_in};
    assign y_ext = {{(TCW+1){y_ff[W-1]}}, y_ff};
    assign tc_ext = {{(W+1){1'b0}}, tc_steps};

    // Accumulator holds y times T; y follows x by 1/T per step
    always @* begin
        nxt_acc = acc_ff;
        if (load) begin
            nxt_acc = x_ext * tc_ext;
        end else if (tc_steps != tc_seen_ff) begin
            // New T rescales the sum so the output does not jump
            nxt_acc = y_ext * tc_ext;
        end else if (step_en) begin
            nxt_acc = acc_ff + x_ext - y_ext;
        end
        quot = nxt_acc / tc_ext;
        nxt_y = quot[W-1:0];
    end

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= {(W+TCW+1){1'b0}};
            tc_seen_ff <= {TCW{1'b0}};
            y_ff <= {W{1'b0}};
        end else begin
            acc_ff <= nxt_acc;
            tc_seen_ff <= tc_steps;
            y_ff <= nxt_y;
        end
    end
endmodule

// [hw/aic_conditioner.v]
// Analogue input conditioning: range, scaling, smoothing and gating.
// Assumes sample and settings synchronous to mclk, 125 MHz.
`timescale 1ns/1ps
`include "aic_defines.vh"

module aic_conditioner #(
    parameter PW = 32,
    parameter NDI = 4,
    parameter MS_CYCLES = `AIC_MS_CYCLES
) (
    input wire mclk,
    input wire rst_b,
    input wire sample_valid,
    input wire [15:0] sample_level,
    input wire current_voltage_jumper,
    input wire [1:0] input_function_select,
    input wire setup_write,
    input wire [2:0] setup_write_value,
    input wire user_span_write,
    input wire [15:0] physical_span_low,
    input wire [15:0] physical_span_high,
    input wire [1:0] process_low_select,
    input wire [1:0] process_high_select,
    input wire user_value_write,
    input wire signed [PW-1:0] process_low_user_value,
    input wire signed [PW-1:0] process_high_user_value,
    input wire signed [PW-1:0] function_min_value,
    input wire signed [PW-1:0] function_max_value,
    input wire [15:0] smoothing_time_constant,
    input wire [1:0] input_gate_select,
    input wire [NDI*5-1:0] gate_when_input_low_function,
    input wire [NDI-1:0] gate_when_input_low_level,
    output reg [2:0] input_range_setup_ff,
    output reg unit_is_volts_ff,
    output reg [15:0] span_low_ff,
    output reg [15:0] span_high_ff,
    output reg signed [PW-1:0] process_value_ff,
    output reg process_value_valid_ff,
    output reg signed [PW-1:0] comparator_value_ff,
    output reg input_active_ff
);
    reg [16:0] ms_cnt_ff;
    reg ms_tick_ff;
    reg [15:0] user_low_ff;
    reg [15:0] user_high_ff;
    reg signed [PW-1:0] user_lo_val_ff;
    reg signed [PW-1:0] user_hi_val_ff;
    reg signed [PW-1:0] scaled_ff;
    reg first_ff;
    reg [15:0] tc_ff;
    reg [2:0] nxt_setup;
    reg [15:0] nxt_lo_phy;
    reg [15:0] nxt_hi_phy;
    reg signed [PW-1:0] pv_lo;
    reg signed [PW-1:0] pv_hi;
    reg signed [PW-1:0] nxt_scaled;
    reg signed [PW+17:0] prod;
    reg signed [17:0] num;
    reg signed [17:0] den;
    reg [15:0] clamped;
    reg [15:0] span_min;
    reg [15:0] span_max;
    reg signed [PW+17:0] quot;
    reg gate_sig;
    reg gate_open;
    integer i;
    wire setup_is_volt;
    wire setup_legal;
    wire signed [PW-1:0] filt_y;

    // Jumper restricts selectable setups
    assign setup_is_volt = setup_write_value[2];
    assign setup_legal = (setup_write_value != 3'h3) &&
        (setup_write_value != 3'h7) &&
        (setup_is_volt == current_voltage_jumper);

    function signed [PW-1:0] clamp_pv;
        input signed [PW-1:0] v;
        begin
            if (v > $signed(`AIC_PV_LIMIT)) begin
                clamp_pv = `AIC_PV_LIMIT;
            end else if (v < -$signed(`AIC_PV_LIMIT)) begin
                clamp_pv = -$signed(`AIC_PV_LIMIT);
            end else begin
                clamp_pv = v;
            end
        end
    endfunction

    function [15:0] clamp_phy;
        input [15:0] v;
        input volts;
        begin
            if (volts && v > `AIC_PHY_10V) begin
                clamp_phy = `AIC_PHY_10V;
            end else if (!volts && v > `AIC_PHY_20MA) begin
                clamp_phy = `AIC_PHY_20MA;
            end else begin
                clamp_phy = v;
            end
        end
    endfunction

    // Physical span per setup
    always @* begin
        nxt_setup = input_range_setup_ff;
        // Stored setup changes only by legal write
        if (setup_write && setup_legal) begin
            nxt_setup = setup_write_value;
        end
        nxt_lo_phy = `AIC_PHY_ZERO;
        nxt_hi_phy = `AIC_PHY_20MA;
        case (input_range_setup_ff)
            `AIC_SU_4_20MA: begin
                nxt_lo_phy = `AIC_PHY_4MA;
                nxt_hi_phy = `AIC_PHY_20MA;
            end
            `AIC_SU_0_20MA: begin
                nxt_lo_phy = `AIC_PHY_ZERO;
                nxt_hi_phy = `AIC_PHY_20MA;
            end
            `AIC_SU_0_10V: begin
                nxt_lo_phy = `AIC_PHY_ZERO;
                nxt_hi_phy = `AIC_PHY_10V;
            end
            `AIC_SU_2_10V: begin
                nxt_lo_phy = `AIC_PHY_2V;
                nxt_hi_phy = `AIC_PHY_10V;
            end
            `AIC_SU_USER_CURRENT_RANGE, `AIC_SU_USER_V: begin
                nxt_lo_phy = user_low_ff;
                nxt_hi_phy = user_high_ff;
            end
            default: begin
                nxt_lo_phy = `AIC_PHY_ZERO;
                nxt_hi_phy = `AIC_PHY_20MA;
            end
        endcase
    end

    // Process ends by select code
    always @* begin
        case (process_low_select)
            `AIC_PS_MIN: pv_lo = function_min_value;
            `AIC_PS_MAX: pv_lo = function_max_value;
            `AIC_PS_USER: pv_lo = user_lo_val_ff;
            default: pv_lo = function_min_value;
        endcase
        case (process_high_select)
            `AIC_PS_MIN: pv_hi = function_min_value;
            `AIC_PS_MAX: pv_hi = function_max_value;
            `AIC_PS_USER: pv_hi = user_hi_val_ff;
            default: pv_hi = function_max_value;
        endcase
    end

    always @* begin
        // A reversed user span still clamps to its two ends
        if (span_low_ff <= span_high_ff) begin
            span_min = span_low_ff;
            span_max = span_high_ff;
        end else begin
            span_min = span_high_ff;
            span_max = span_low_ff;
        end
        if (sample_level < span_min) begin
            clamped = span_min;
        end else if (sample_level > span_max) begin
            clamped = span_max;
        end else begin
            clamped = sample_level;
        end
        num = $signed({2'b00, clamped}) - $signed({2'b00, span_low_ff});
        den = $signed({2'b00, span_high_ff}) -
            $signed({2'b00, span_low_ff});
        prod = (pv_hi - pv_lo) * num;
        quot = {(PW+18){1'b0}};
        if (den == 18'sh0) begin
            nxt_scaled = pv_lo;
        end else begin
            quot = prod / den;
            nxt_scaled = pv_lo + quot[PW-1:0];
        end
    end

    // Gate from inputs set to function 11
    always @* begin
        gate_sig = 1'b0;
        for (i = 0; i < NDI; i = i + 1) begin
            if (gate_when_input_low_function[i*5 +: 5] == `AIC_DI_GATE_FN) begin
                gate_sig = gate_sig | gate_when_input_low_level[i];
            end
        end
        case (input_gate_select)
            `AIC_GT_ON: gate_open = 1'b1;
            `AIC_GT_LOW: gate_open = ~gate_sig;
            `AIC_GT_HIGH: gate_open = gate_sig;
            default: gate_open = 1'b1;
        endcase
    end

    // Millisecond step divider
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ms_cnt_ff <= 17'h0;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff == MS_CYCLES - 1) begin
            ms_cnt_ff <= 17'h0;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 17'h1;
            ms_tick_ff <= 1'b0;
        end
    end

    // Settings and span registers
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            input_range_setup_ff <= `AIC_SU_4_20MA;
            unit_is_volts_ff <= 1'b0;
            // Low default range bottom, 4 mA for current
            user_low_ff <= `AIC_PHY_4MA;
            user_high_ff <= `AIC_PHY_20MA;
            user_lo_val_ff <= `AIC_PV_ZERO;
            user_hi_val_ff <= `AIC_PV_ZERO;
            span_low_ff <= `AIC_PHY_4MA;
            span_high_ff <= `AIC_PHY_20MA;
            tc_ff <= `AIC_TC_DEF_MS;
        end else begin
            input_range_setup_ff <= nxt_setup;
            unit_is_volts_ff <= nxt_setup[2];
            if (user_span_write) begin
                user_low_ff <= clamp_phy(physical_span_low,
                    input_range_setup_ff[2]);
                user_high_ff <= clamp_phy(physical_span_high,
                    input_range_setup_ff[2]);
            end else if (nxt_setup[2] != input_range_setup_ff[2]) begin
                user_low_ff <= nxt_setup[2] ? `AIC_PHY_ZERO :
                    `AIC_PHY_4MA;
                user_high_ff <= nxt_setup[2] ? `AIC_PHY_10V :
                    `AIC_PHY_20MA;
            end
            if (user_value_write) begin
                user_lo_val_ff <= clamp_pv(process_low_user_value);
                user_hi_val_ff <= clamp_pv(process_high_user_value);
            end
            span_low_ff <= nxt_lo_phy;
            span_high_ff <= nxt_hi_phy;
            if (smoothing_time_constant < `AIC_TC_MIN_MS) begin
                tc_ff <= `AIC_TC_MIN_MS;
            end else if (smoothing_time_constant > `AIC_TC_MAX_MS) begin
                tc_ff <= `AIC_TC_MAX_MS;
            end else begin
                tc_ff <= smoothing_time_constant;
            end
        end
    end

    // Scaled sample capture
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scaled_ff <= `AIC_PV_ZERO;
            first_ff <= 1'b1;
        end else begin
            if (sample_valid) begin
                scaled_ff <= nxt_scaled;
            end
            if (ms_tick_ff) begin
                first_ff <= 1'b0;
            end
        end
    end

    aic_lowpass #(
        .W(PW),
        .TCW(16)
    ) u_lowpass (
        .mclk(mclk),
        .rst_b(rst_b),
        .step_en(ms_tick_ff),
        .load(first_ff & ms_tick_ff),
        .tc_steps(tc_ff),
        .x_in(scaled_ff),
        .y_ff(filt_y)
    );

    // Outputs
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            process_value_ff <= `AIC_PV_ZERO;
            process_value_valid_ff <= 1'b0;
            comparator_value_ff <= `AIC_PV_ZERO;
            input_active_ff <= 1'b0;
        end else begin
            comparator_value_ff <= filt_y;
            input_active_ff <= gate_open;
            // Process value only for function 3
            if (input_function_select == `AIC_FN_PROCESS && gate_open) begin
                process_value_ff <= filt_y;
                process_value_valid_ff <= 1'b1;
            end else begin
                process_value_valid_ff <= 1'b0;
            end
        end
    end
endmodule

// [testbench/aic_properties.sv]
// Port checker for the analogue input conditioner.
// Bound to aic_conditioner; sees its ports only.
`timescale 1ns/1ps
module aic_properties #(
    parameter PW = 32
) (
    input wire mclk,
    input wire rst_b,
    input wire setup_write,
    input wire [2:0] setup_write_value,
    input wire current_voltage_jumper,
    input wire [1:0] input_function_select,
    input wire [1:0] input_gate_select,
    input wire [2:0] input_range_setup_ff,
    input wire unit_is_volts_ff,
    input wire [15:0] span_low_ff,
    input wire [15:0] span_high_ff,
    input wire signed [PW-1:0] process_value_ff,
    input wire process_value_valid_ff,
    input wire input_active_ff
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    wire [2:0] su = input_range_setup_ff;
    wire ok_wr = setup_write && setup_write_value[1:0] != 2'h3 &&
        setup_write_value[2] == current_voltage_jumper;

    property p_setup_take;
        ok_wr |=> su == $past(setup_write_value);
    endproperty
    a_setup_take: assert property (p_setup_take)
        else $error("legal setup write not taken");
    property p_setup_keep;
        !ok_wr |=> $stable(su);
    endproperty
    a_setup_keep: assert property (p_setup_keep)
        else $error("setup changed without a legal write");
    property p_setup_legal;
        su[1:0] != 2'h3;
    endproperty
    a_setup_legal: assert property (p_setup_legal)
        else $error("setup holds an unknown code");
    property p_unit;
        $stable(su)[*2] |-> unit_is_volts_ff == su[2];
    endproperty
    a_unit: assert property (p_unit)
        else $error("unit does not follow setup");
    property p_live_ma;
        ($stable(su) && su == 3'h0)[*2] |->
            span_low_ff == 16'h0190 && span_high_ff == 16'h07d0;
    endproperty
    a_live_ma: assert property (p_live_ma)
        else $error("current live zero span wrong");
    property p_full;
        ($stable(su) && (su == 3'h1 || su == 3'h4))[*2] |->
            span_low_ff == 16'h0000 &&
            span_high_ff == (su[2] ? 16'h03e8 : 16'h07d0);
    endproperty
    a_full: assert property (p_full)
        else $error("full scale span wrong");
    property p_live_v;
        ($stable(su) && su == 3'h5)[*2] |->
            span_low_ff == 16'h00c8 && span_high_ff == 16'h03e8;
    endproperty
    a_live_v: assert property (p_live_v)
        else $error("voltage live zero span wrong");
    property p_fn_off;
        (input_function_select == 2'h0)[*4] |-> !process_value_valid_ff;
    endproperty
    a_fn_off: assert property (p_fn_off)
        else $error("process value valid while input off");
    property p_hold;
        !process_value_valid_ff |-> $stable(process_value_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("process value moved while not valid");
    property p_gate_on;
        (input_gate_select == 2'h0 && input_function_select == 2'h3)[*4]
            |-> input_active_ff;
    endproperty
    a_gate_on: assert property (p_gate_on)
        else $error("input inactive with gate always on");
endmodule

bind aic_conditioner aic_properties #(.PW(PW)) chk_u (.mclk, .rst_b,
    .setup_write, .setup_write_value, .current_voltage_jumper,
    .input_function_select, .input_gate_select, .input_range_setup_ff,
    .unit_is_volts_ff, .span_low_ff, .span_high_ff, .process_value_ff,
    .process_value_valid_ff, .input_active_ff);

// [testbench/aic_sensor_model.sv]
// Behavioural process sensor with its converter.
// Emits one sample every 2 cycles, or every 16 when slow.
`timescale 1ns/1ps
module aic_sensor_model (
    input wire mclk,
    input wire rst_b,
    input wire slow,
    input wire [15:0] level,
    output reg sample_valid,
    output reg [15:0] sample_level
);
    reg [3:0] cnt_ff;
    wire nxt_valid = slow ? (cnt_ff == 4'hf) : cnt_ff[0];
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 4'h0;
            sample_valid <= 1'b0;
            sample_level <= 16'h0000;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            sample_valid <= nxt_valid;
            // Level is junk between samples
            sample_level <= nxt_valid ? level : ~level;
        end
    end
endmodule

// [testbench/aic_conditioner_tb_top.sv]
// Bench for aic_conditioner fed by the sensor model.
// Assumes the checker is bound; millisecond tick shortened to 4 cycles.
`timescale 1ns/1ps
module aic_conditioner_tb_top;
    reg mclk, rst_b, current_voltage_jumper, setup_write, user_span_write;
    reg user_value_write, slow;
    reg [2:0] setup_write_value;
    reg [15:0] physical_span_low, physical_span_high, lvl;
    reg [15:0] smoothing_time_constant;
    reg [1:0] input_function_select, process_low_select;
    reg [1:0] process_high_select, input_gate_select;
    reg signed [31:0] process_low_user_value, process_high_user_value;
    reg signed [31:0] function_min_value, function_max_value;
    reg [19:0] gate_when_input_low_function;
    reg [3:0] gate_when_input_low_level;
    wire sample_valid, unit_is_volts_ff, process_value_valid_ff;
    wire input_active_ff;
    wire [15:0] sample_level, span_low_ff, span_high_ff;
    wire [2:0] input_range_setup_ff;
    wire signed [31:0] process_value_ff, comparator_value_ff;
    integer num_errors, n_compared, k;
    reg [39:0] rows [0:5];
    reg [3:0] gate_rows [0:3];

    aic_sensor_model sensor_u (.mclk, .rst_b, .slow, .level(lvl),
        .sample_valid, .sample_level);
    aic_conditioner #(.MS_CYCLES(4)) dut_u (.mclk, .rst_b, .sample_valid,
        .sample_level, .current_voltage_jumper, .input_function_select,
        .setup_write, .setup_write_value, .user_span_write,
        .physical_span_low, .physical_span_high, .process_low_select,
        .process_high_select, .user_value_write, .process_low_user_value,
        .process_high_user_value, .function_min_value, .function_max_value,
        .smoothing_time_constant, .input_gate_select, .gate_when_input_low_function,
        .gate_when_input_low_level, .input_range_setup_ff, .unit_is_volts_ff, .span_low_ff,
        .span_high_ff, .process_value_ff, .process_value_valid_ff,
        .comparator_value_ff, .input_active_ff);

    always #4 mclk = ~mclk;

    task end_of_test;
        begin
            $display("errors %0d compared %0d", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("unexpected %s: expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // Bounded wait until the comparator value equals e, or leaves it
    task settle(input logic [31:0] e, input logic eq);
        integer i;
        begin
            i = 0;
            while (((comparator_value_ff === e) != eq) && i < 400) begin
                @(negedge mclk);
                i = i + 1;
            end
            if ((comparator_value_ff === e) != eq) begin
                num_errors = num_errors + 1;
                $display("unexpected comparator_wait: expected %h seen %h",
                    e, comparator_value_ff);
                end_of_test;
            end
        end
    endtask

    task smp(input [15:0] s, input logic [31:0] e);
        begin
            lvl = s;
            settle(e, 1'b1);
            repeat (2) @(negedge mclk);
        end
    endtask

    task put(input logic j, input [2:0] c);
        begin
            current_voltage_jumper = j;
            setup_write_value = c;
            setup_write = 1'b1;
            @(negedge mclk);
            setup_write = 1'b0;
            repeat (3) @(negedge mclk);
        end
    endtask

    initial begin
        mclk = 1'b0;
        {rst_b, current_voltage_jumper, setup_write, user_span_write} = 4'h0;
        {user_value_write, slow, setup_write_value} = 5'h00;
        {physical_span_low, physical_span_high, lvl} = 48'h0;
        {input_function_select, process_low_select} = 4'hc;
        {process_high_select, input_gate_select} = 4'h4;
        {process_low_user_value, process_high_user_value} = 64'h0;
        function_min_value = 32'h0;
        function_max_value = 32'h1f40;
        smoothing_time_constant = 16'h0001;
        {gate_when_input_low_function, gate_when_input_low_level} = 24'h0000b0;
        num_errors = 0;
        n_compared = 0;
        rows[0] = {1'b0, 3'h1, 3'h1, 16'h0000, 16'h07d0, 1'b0};
        rows[1] = {1'b0, 3'h4, 3'h1, 16'h0000, 16'h07d0, 1'b0};
        rows[2] = {1'b0, 3'h0, 3'h0, 16'h0190, 16'h07d0, 1'b0};
        rows[3] = {1'b1, 3'h5, 3'h5, 16'h00c8, 16'h03e8, 1'b1};
        rows[4] = {1'b0, 3'h7, 3'h5, 16'h00c8, 16'h03e8, 1'b1};
        rows[5] = {1'b1, 3'h4, 3'h4, 16'h0000, 16'h03e8, 1'b1};
        gate_rows[0] = 4'h6;
        gate_rows[1] = 4'h5;
        gate_rows[2] = 4'h8;
        gate_rows[3] = 4'hb;
        repeat (6) @(negedge mclk);
        chk("setup", 32'h0, input_range_setup_ff);
        chk("span_low", 32'h190, span_low_ff);
        chk("valid", 32'h0, process_value_valid_ff);
        rst_b = 1'b1;
        @(negedge mclk);
        chk("valid_on", 32'h1, process_value_valid_ff);
        for (k = 0; k < 6; k = k + 1) begin
            put(rows[k][39], rows[k][38:36]);
            chk("setup", rows[k][35:33], input_range_setup_ff);
            chk("span_low", rows[k][32:17], span_low_ff);
            chk("span_high", rows[k][16:1], span_high_ff);
            chk("unit", rows[k][0], unit_is_volts_ff);
        end
        put(1'b1, 3'h6);
        {physical_span_low, physical_span_high} = {16'h0064, 16'h0384};
        user_span_write = 1'b1;
        @(negedge mclk);
        user_span_write = 1'b0;
        repeat (3) @(negedge mclk);
        chk("span_user", 32'h00640384, {span_low_ff, span_high_ff});
        smp(16'h01f4, 32'hfa0);
        chk("pv", 32'hfa0, process_value_ff);
        chk("valid", 32'h1, process_value_valid_ff);
        process_low_user_value = 32'hfffffc18;
        process_high_user_value = 32'hbb8;
        {process_low_select, process_high_select} = 4'ha;
        user_value_write = 1'b1;
        @(negedge mclk);
        user_value_write = 1'b0;
        smp(16'h0384, 32'hbb8);
        chk("pv_user_high", 32'hbb8, process_value_ff);
        smp(16'h0064, 32'hfffffc18);
        chk("pv_user_low", 32'hfffffc18, process_value_ff);
        {process_low_select, process_high_select} = 4'h4;
        smp(16'h012c, 32'h1770);
        chk("pv_swapped", 32'h1770, process_value_ff);
        input_function_select = 2'h0;
        smp(16'h01f4, 32'hfa0);
        chk("valid_off", 32'h0, process_value_valid_ff);
        chk("pv_held", 32'h1770, process_value_ff);
        input_function_select = 2'h3;
        for (k = 0; k < 4; k = k + 1) begin
            {input_gate_select, gate_when_input_low_level[0]} = gate_rows[k][3:1];
            repeat (4) @(negedge mclk);
            chk("active", gate_rows[k][0], input_active_ff);
            chk("valid", gate_rows[k][0], process_value_valid_ff);
        end
        input_gate_select = 2'h0;
        smoothing_time_constant = 16'h0004;
        slow = 1'b1;
        lvl = 16'h0384;
        settle(32'hfa0, 1'b0);
        chk("filter_step", 32'hbb8, comparator_value_ff);
        repeat (100) @(negedge mclk);
        chk("filter_settled", 32'h1,
            comparator_value_ff >= 0 && comparator_value_ff < 40);
        // Mid-run reset, then user span defaults per range
        rst_b = 1'b0;
        @(negedge mclk);
        chk("rst_valid", 32'h0, process_value_valid_ff);
        chk("rst_cmp", 32'h0, comparator_value_ff);
        rst_b = 1'b1;
        put(1'b0, 3'h2);
        chk("span_dflt_ma", 32'h019007d0, {span_low_ff, span_high_ff});
        put(1'b1, 3'h6);
        chk("span_dflt_v", 32'h000003e8, {span_low_ff, span_high_ff});
        end_of_test;
    end
endmodule
